// ===== design/fmpmu_pkg.sv
package fmpmu_pkg;

    // ==========================================================
    // Opcode prefixes and field positions
    localparam logic [11:0] MAC_MOVE_PREFIX = 12'he33;
    localparam logic [13:0] PAR_PREFIX      = 14'h39d0;
    localparam int LO_MM_RF_HI = 3;
    localparam int LO_MM_RF_LO = 1;
    localparam int LO_MM_RE_HI = 0;
    localparam int HI_MM_RE_HI = 15;
    localparam int HI_MM_RE_LO = 14;
    localparam int HI_MM_RD_HI = 13;
    localparam int HI_MM_RD_LO = 11;
    localparam int HI_MM_RA_HI = 10;
    localparam int HI_MM_RA_LO = 8;
    localparam int LO_PA_F_HI  = 1;
    localparam int LO_PA_F_LO  = 0;
    localparam int HI_PA_F     = 15;
    localparam int HI_PA_E_LO  = 12;
    localparam int HI_PA_D_LO  = 9;
    localparam int HI_PA_C_LO  = 6;
    localparam int HI_PA_B_LO  = 3;
    localparam int HI_PA_A_LO  = 0;

    // ==========================================================
    // Fixed registers and float format
    localparam logic [2:0]         ACC_REG     = 3'h3;
    localparam logic [2:0]         ADDEND_REG  = 3'h2;
    localparam int                 SIGN_BIT    = 31;
    localparam int                 EXP_HI      = 30;
    localparam int                 EXP_LO      = 23;
    localparam logic signed [10:0] EXP_BIAS    = 11'sh07f;
    localparam logic signed [10:0] EXP_MAX     = 11'sh0ff;
    localparam logic [30:0]        FLT_MAX_MAG = 31'h7f7fffff;

    // ==========================================================
    // Flag and event bit positions
    localparam int FS_LVF = 0;
    localparam int FS_LUF = 1;
    localparam int FS_NF  = 2;
    localparam int FS_ZF  = 3;
    localparam int FS_NI  = 4;
    localparam int FS_ZI  = 5;
    localparam int FS_TF  = 6;
    localparam int FS_W   = 7;
    localparam int EV_DONE   = 0;
    localparam int EV_UNF    = 1;
    localparam int EV_OVF    = 2;
    localparam int EV_REFUSE = 3;
    localparam int EV_W      = 4;

    // ==========================================================
    // Wishbone byte addresses
    localparam int          ADR_W       = 8;
    localparam logic [7:0]  ADR_FSTAT   = 8'h00;
    localparam logic [7:0]  ADR_EVSTAT  = 8'h04;
    localparam logic [7:0]  ADR_EVCLR   = 8'h08;
    localparam logic [7:0]  ADR_EVEN    = 8'h0c;
    localparam logic [7:0]  ADR_RF_BASE = 8'h20;
    localparam logic [31:0] RESET_WORD  = 32'h0;

    typedef enum logic [1:0] {FMPMU_NONE, FMPMU_MAC_MOVE, FMPMU_PAR, FMPMU_BAD} fmpmu_kind_t;

endpackage

// ===== design/fmpmu_regfile.sv
`timescale 1ns/100ps
module fmpmu_regfile
    import fmpmu_pkg::*;
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8,
    parameter int NRD   = 5,
    parameter int NWR   = 4,
    parameter int AW    = $clog2(DEPTH)
)
(
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    // Read ports, data registered
    input  wire logic [NRD*AW-1:0]    rd_addr,
    output logic      [NRD*WIDTH-1:0] rd_data,
    // Write ports, higher index wins
    input  wire logic [NWR-1:0]       wr_en,
    input  wire logic [NWR*AW-1:0]    wr_addr,
    input  wire logic [NWR*WIDTH-1:0] wr_data
);

    logic [WIDTH-1:0] mem [DEPTH];

    // ==========================================================
    // Storage
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < DEPTH; i++)
                mem[i] <= WIDTH'(RESET_WORD);
        end
        else
        begin
            for (int w = 0; w < NWR; w++)
                if (wr_en[w])
                    mem[wr_addr[w*AW +: AW]] <= wr_data[w*WIDTH +: WIDTH];
        end
    end

    // ==========================================================
    // Reads see the value before this edge's writes
    always_ff @(posedge clk)
    begin
        for (int r = 0; r < NRD; r++)
            rd_data[r*WIDTH +: WIDTH] <= mem[rd_addr[r*AW +: AW]];
    end

endmodule

// ===== design/fmpmu_core.sv
// What this block does
// - A parallel multiply and a parallel add both take two cycles and write their destinations together.
// - The multiply-accumulate-with-move form is decoded from its prefix and split 3-bit register fields.
// - That form adds the addend into the accumulator, writes the product, and loads the memory word.
// - Underflow or overflow from either half sets its latched flag, which the instruction never clears.
// - That form updates both negative and zero flag pairs and both latches, never the test flag.
// - Float negative copies bit 31 and float zero clears, unless the exponent is zero, which sets zero and clears negative.
// - Integer negative copies bit 31 and integer zero is set only for an all-zero word.
// - The move lands at the end of the issue cycle, the arithmetic results one cycle later.
// - The alias is a multiply into a chosen register plus accumulator add; rd equal to the accumulator is not refused and the add result wins.
`timescale 1ns/100ps
module fmpmu_core
    import fmpmu_pkg::*;
#(
    parameter int NREG = 8
)
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             sys_rst,
    // Wishbone slave
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    // Instruction issue from the host pipeline
    input  wire logic             issue_valid,
    input  wire logic [15:0]      issue_low,
    input  wire logic [15:0]      issue_high,
    input  wire logic [31:0]      memory_word_operand,
    // Results
    output logic                  exec_done,
    output logic      [FS_W-1:0]  float_status_register,
    output logic                  irq
);

    localparam int AW = $clog2(NREG);

    // ==========================================================
    // Helpers
    function automatic logic [31:0] byte_mask(input logic [3:0] sel);
        byte_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction

    // Truncating multiply; returns {underflow, overflow, result}
    function automatic logic [33:0] fmul(input logic [31:0] a, input logic [31:0] b);
        logic               s;
        logic [47:0]        p;
        logic signed [10:0] e;
        logic [22:0]        m;
        s = a[SIGN_BIT] ^ b[SIGN_BIT];
        p = {1'b1, a[EXP_LO-1:0]} * {1'b1, b[EXP_LO-1:0]};
        e = $signed({3'h0, a[EXP_HI:EXP_LO]}) + $signed({3'h0, b[EXP_HI:EXP_LO]}) - EXP_BIAS;
        m = p[45:23];
        if (p[47])
        begin
            e = e + 11'sh001;
            m = p[46:24];
        end
        if (a[EXP_HI:EXP_LO] == 8'h00 || b[EXP_HI:EXP_LO] == 8'h00)
            fmul = {2'b00, s, 31'h0};
        else if (e >= EXP_MAX)
            fmul = {2'b01, s, FLT_MAX_MAG};
        else if (e <= 11'sh000)
            fmul = {2'b10, s, 31'h0};
        else
            fmul = {2'b00, s, e[7:0], m};
    endfunction

    // Truncating add; returns {underflow, overflow, result}
    function automatic logic [33:0] fadd(input logic [31:0] a, input logic [31:0] b);
        logic [31:0]        x;
        logic [31:0]        y;
        logic [25:0]        mx;
        logic [25:0]        my;
        logic [25:0]        sm;
        logic [7:0]         d;
        logic signed [10:0] e;
        x = a;
        y = b;
        if (a[EXP_HI:0] < b[EXP_HI:0])
        begin
            x = b;
            y = a;
        end
        d  = x[EXP_HI:EXP_LO] - y[EXP_HI:EXP_LO];
        mx = {2'b01, x[EXP_LO-1:0], 1'b0};
        my = {2'b01, y[EXP_LO-1:0], 1'b0} >> d;
        sm = (x[SIGN_BIT] == y[SIGN_BIT]) ? mx + my : mx - my;
        e  = $signed({3'h0, x[EXP_HI:EXP_LO]});
        if (sm[25])
        begin
            sm = sm >> 1;
            e  = e + 11'sh001;
        end
        for (int i = 0; i < 25; i++)
        begin
            if (!sm[24] && sm != 26'h0)
            begin
                sm = sm << 1;
                e  = e - 11'sh001;
            end
        end
        if (y[EXP_HI:EXP_LO] == 8'h00)
            fadd = {2'b00, x};
        else if (sm == 26'h0)
            fadd = 34'h0;
        else if (e >= EXP_MAX)
            fadd = {2'b01, x[SIGN_BIT], FLT_MAX_MAG};
        else if (e <= 11'sh000)
            fadd = {2'b10, x[SIGN_BIT], 31'h0};
        else
            fadd = {2'b00, x[SIGN_BIT], e[7:0], sm[23:1]};
    endfunction

    // ==========================================================
    // Decode
    fmpmu_kind_t      kind;
    logic [AW-1:0]    mul_src1;
    logic [AW-1:0]    mul_src2;
    logic [AW-1:0]    mul_dst;
    logic [AW-1:0]    add_src1;
    logic [AW-1:0]    add_src2;
    logic [AW-1:0]    add_dst;
    logic [AW-1:0]    move_dst;

    always_comb
    begin
        kind     = FMPMU_NONE;
        mul_src1 = issue_high[HI_PA_B_LO +: AW];
        mul_src2 = issue_high[HI_PA_C_LO +: AW];
        mul_dst  = issue_high[HI_PA_A_LO +: AW];
        add_src1 = issue_high[HI_PA_E_LO +: AW];
        add_src2 = {issue_low[LO_PA_F_HI:LO_PA_F_LO], issue_high[HI_PA_F]};
        add_dst  = issue_high[HI_PA_D_LO +: AW];
        move_dst = issue_high[HI_MM_RA_HI:HI_MM_RA_LO];
        if (issue_valid && issue_low[15:4] == MAC_MOVE_PREFIX)
        begin
            kind     = FMPMU_MAC_MOVE;
            mul_src1 = {issue_low[LO_MM_RE_HI], issue_high[HI_MM_RE_HI:HI_MM_RE_LO]};
            mul_src2 = issue_low[LO_MM_RF_HI:LO_MM_RF_LO];
            mul_dst  = issue_high[HI_MM_RD_HI:HI_MM_RD_LO];
            add_src1 = ACC_REG;
            add_src2 = ADDEND_REG;
            add_dst  = ACC_REG;
        end
        else if (issue_valid && issue_low[15:2] == PAR_PREFIX)
        begin
            // Equal destinations would race; the pair is refused instead
            kind = (mul_dst == add_dst) ? FMPMU_BAD : FMPMU_PAR;
        end
        else if (issue_valid)
        begin
            kind = FMPMU_BAD;
        end
    end

    // ==========================================================
    // Register file
    logic [5*32-1:0]  rd_data;
    logic [3:0]       wr_en;
    logic [4*AW-1:0]  wr_addr;
    logic [4*32-1:0]  wr_data;
    logic             bus_req;
    logic             bus_rf;
    logic [AW-1:0]    bus_idx;
    logic [31:0]      bus_rf_word;
    logic [33:0]      mul_res;
    logic [33:0]      add_res;
    logic             s1_valid;
    logic [AW-1:0]    s1_mul_dst;
    logic [AW-1:0]    s1_add_dst;
    logic             wb_pend;

    assign bus_idx     = wb_adr_i[AW+1:2];
    assign bus_rf      = (wb_adr_i & ~ADR_W'((NREG * 4) - 1)) == ADR_RF_BASE;
    assign bus_req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_rf_word = (rd_data[4*32 +: 32] & ~byte_mask(wb_sel_i)) | (wb_dat_i & byte_mask(wb_sel_i));
    // Operands captured at issue by the registered read ports
    assign mul_res     = fmul(rd_data[0 +: 32], rd_data[32 +: 32]);
    assign add_res     = fadd(rd_data[64 +: 32], rd_data[96 +: 32]);
    // Move lands at issue end, arithmetic one edge later
    assign wr_en   = {s1_valid, s1_valid, kind == FMPMU_MAC_MOVE,
                      wb_pend && wb_we_i && bus_rf};
    assign wr_addr = {s1_add_dst, s1_mul_dst, move_dst, bus_idx};
    assign wr_data = {add_res[31:0], mul_res[31:0], memory_word_operand, bus_rf_word};

    fmpmu_regfile #(
        .WIDTH (32),
        .DEPTH (NREG),
        .NRD   (5),
        .NWR   (4)
    ) u_regfile (
        .clk     (clk),
        .sys_rst (sys_rst),
        .rd_addr ({bus_idx, add_src2, add_src1, mul_src2, mul_src1}),
        .rd_data (rd_data),
        .wr_en   (wr_en),
        .wr_addr (wr_addr),
        .wr_data (wr_data)
    );

    // ==========================================================
    // Execute stage
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            s1_valid   <= 1'b0;
            s1_mul_dst <= '0;
            s1_add_dst <= '0;
            exec_done  <= 1'b0;
        end
        else
        begin
            s1_valid   <= kind == FMPMU_MAC_MOVE || kind == FMPMU_PAR;
            s1_mul_dst <= mul_dst;
            s1_add_dst <= add_dst;
            exec_done  <= s1_valid;
        end
    end

    // ==========================================================
    // Float status flags
    logic [FS_W-1:0] next_fstat;
    logic [31:0]     mv;

    assign mv = memory_word_operand;

    always_comb
    begin
        next_fstat = float_status_register;
        if (wb_pend && wb_we_i && wb_adr_i == ADR_FSTAT && wb_sel_i[0])
            next_fstat = wb_dat_i[FS_W-1:0];
        if (kind == FMPMU_MAC_MOVE)
        begin
            // Test flag is left alone
            next_fstat[FS_NF] = mv[SIGN_BIT];
            next_fstat[FS_ZF] = 1'b0;
            if (mv[EXP_HI:EXP_LO] == 8'h00)
            begin
                next_fstat[FS_ZF] = 1'b1;
                next_fstat[FS_NF] = 1'b0;
            end
            next_fstat[FS_NI] = mv[SIGN_BIT];
            next_fstat[FS_ZI] = mv == 32'h0;
        end
        if (s1_valid)
        begin
            // Latches only ever set here, so a same-edge software clear loses to a flag this result raises
            next_fstat[FS_LUF] = next_fstat[FS_LUF] | mul_res[33] | add_res[33];
            next_fstat[FS_LVF] = next_fstat[FS_LVF] | mul_res[32] | add_res[32];
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            float_status_register <= '0;
        else
            float_status_register <= next_fstat;
    end

    // ==========================================================
    // Interrupt events
    logic [EV_W-1:0] ev_status;
    logic [EV_W-1:0] ev_enable;
    logic [EV_W-1:0] ev_set;
    logic [EV_W-1:0] ev_clr;

    always_comb
    begin
        ev_set            = '0;
        ev_set[EV_DONE]   = s1_valid;
        ev_set[EV_UNF]    = s1_valid && (mul_res[33] || add_res[33]);
        ev_set[EV_OVF]    = s1_valid && (mul_res[32] || add_res[32]);
        ev_set[EV_REFUSE] = kind == FMPMU_BAD;
        ev_clr            = '0;
        if (wb_pend && wb_we_i && wb_adr_i == ADR_EVCLR && wb_sel_i[0])
            ev_clr = wb_dat_i[EV_W-1:0];
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            ev_status <= '0;
            ev_enable <= '0;
            irq       <= 1'b0;
        end
        else
        begin
            // Set wins over a clear in the same cycle
            ev_status <= (ev_status & ~ev_clr) | ev_set;
            if (wb_pend && wb_we_i && wb_adr_i == ADR_EVEN && wb_sel_i[0])
                ev_enable <= wb_dat_i[EV_W-1:0];
            irq <= |(((ev_status & ~ev_clr) | ev_set) & ev_enable);
        end
    end

    // ==========================================================
    // Wishbone slave: two-cycle answer so read data leave a flop
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            wb_pend  <= 1'b0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end
        else
        begin
            wb_pend  <= bus_req && !wb_pend;
            wb_ack_o <= wb_pend;
            wb_dat_o <= '0;
            if (wb_pend && !wb_we_i)
            begin
                case (wb_adr_i)
                    ADR_FSTAT:  wb_dat_o <= 32'(float_status_register);
                    ADR_EVSTAT: wb_dat_o <= 32'(ev_status);
                    ADR_EVEN:   wb_dat_o <= 32'(ev_enable);
                    default:    wb_dat_o <= bus_rf ? rd_data[4*32 +: 32] : 32'h0;
                endcase
            end
        end
    end

endmodule

// ===== test/fmpmu_props.sv
`timescale 1ns/100ps
// ==========================================================
// Port-level checker for the core
module fmpmu_props
    import fmpmu_pkg::*;
#(
    parameter int NREG = 8
)
(
    // Clock and reset
    input wire logic             clk,
    input wire logic             sys_rst,
    // Wishbone slave
    input wire logic             wb_cyc_i,
    input wire logic             wb_stb_i,
    input wire logic             wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0]       wb_sel_i,
    input wire logic [31:0]      wb_dat_i,
    input wire logic [31:0]      wb_dat_o,
    input wire logic             wb_ack_o,
    // Instruction issue
    input wire logic             issue_valid,
    input wire logic [15:0]      issue_low,
    input wire logic [15:0]      issue_high,
    input wire logic [31:0]      memory_word_operand,
    // Results
    input wire logic             exec_done,
    input wire logic [FS_W-1:0]  float_status_register,
    input wire logic             irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    logic mm_issue;
    logic par_issue;
    assign mm_issue  = issue_valid && (issue_low[15:4] == MAC_MOVE_PREFIX);
    // Refused pairs (same destination) raise no completion
    assign par_issue = issue_valid && (issue_low[15:2] == PAR_PREFIX) && (issue_high[2:0] != issue_high[11:9]);

    done_latency_a: assert property (mm_issue |-> ##2 exec_done)
        else $error("completion late after mac-move issue");
    par_latency_a: assert property (par_issue |=> !exec_done ##1 exec_done)
        else $error("completion late after parallel issue");
    done_cause_a: assert property (exec_done |-> $past(issue_valid, 2))
        else $error("completion without issue two cycles before");
    fneg_move_a: assert property (mm_issue |=> float_status_register[FS_NF] ==
        ($past(memory_word_operand[31]) && $past(memory_word_operand[30:23]) != 8'h00))
        else $error("float negative flag wrong after move");
    fzero_move_a: assert property (mm_issue |=> float_status_register[FS_ZF] ==
        ($past(memory_word_operand[30:23]) == 8'h00)) else $error("float zero flag wrong after move");
    ineg_move_a: assert property (mm_issue |=> float_status_register[FS_NI] == $past(memory_word_operand[31]))
        else $error("integer negative flag wrong after move");
    izero_move_a: assert property (mm_issue |=> float_status_register[FS_ZI] == ($past(memory_word_operand) == 32'h0))
        else $error("integer zero flag wrong after move");
    test_kept_a: assert property (mm_issue && !wb_cyc_i |=> $stable(float_status_register[FS_TF]))
        else $error("test flag changed by mac-move");
    lvf_sticky_a: assert property (float_status_register[FS_LVF] && !wb_cyc_i |=> float_status_register[FS_LVF])
        else $error("overflow latch dropped without software");
    luf_sticky_a: assert property (float_status_register[FS_LUF] && !wb_cyc_i |=> float_status_register[FS_LUF])
        else $error("underflow latch dropped without software");
endmodule

bind fmpmu_core fmpmu_props #(.NREG(NREG)) chk (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .issue_valid(issue_valid), .issue_low(issue_low),
    .issue_high(issue_high), .memory_word_operand(memory_word_operand), .exec_done(exec_done),
    .float_status_register(float_status_register), .irq(irq));

// ===== test/fmpmu_host.sv
`timescale 1ns/100ps
// ==========================================================
// Host pipeline model issuing instructions
module fmpmu_host
    import fmpmu_pkg::*;
(
    // Clock
    input  wire logic   clk,
    // Issue port
    output logic        issue_valid,
    output logic [15:0] issue_low,
    output logic [15:0] issue_high,
    output logic [31:0] memory_word_operand
);
    initial
    begin
        issue_valid = 1'b0;
        issue_low = 16'h0000;
        issue_high = 16'h0000;
        memory_word_operand = 32'h0;
    end

    task automatic send(input logic [15:0] lo, input logic [15:0] hi, input logic [31:0] mem);
        @(posedge clk);
        issue_valid <= 1'b1;
        issue_low <= lo;
        issue_high <= hi;
        memory_word_operand <= mem;
        @(posedge clk);
        issue_valid <= 1'b0;
        // Released lines show the inverse so a stale operand cannot pass as valid
        issue_low <= ~lo;
        issue_high <= ~hi;
        memory_word_operand <= ~mem;
        @(posedge clk); // Delay slot left empty
    endtask

    // Caller keeps ra apart from the accumulator and from rd
    task automatic mac_move(input logic [2:0] rf, re, rd, ra, input logic [31:0] mem);
        send({MAC_MOVE_PREFIX, rf, re[2]}, {re[1:0], rd, ra, 8'h00}, mem);
    endtask

    task automatic par(input logic [2:0] a, b, c, d, e, f);
        send({PAR_PREFIX, f[2:1]}, {f[0], e, d, c, b, a}, 32'h0);
    endtask
endmodule

// ===== test/tb_fp_mac_parallel_move_unit.sv
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
// ==========================================================
// Self-checking bench
module tb_fp_mac_parallel_move_unit
    import fmpmu_pkg::*;
;
    logic             clk = 1'b0;
    logic             sys_rst = 1'b1;
    logic             wb_cyc_i = 1'b0;
    logic             wb_stb_i = 1'b0;
    logic             wb_we_i = 1'b0;
    logic [ADR_W-1:0] wb_adr_i = 8'h00;
    logic [3:0]       wb_sel_i = 4'hf;
    logic [31:0]      wb_dat_i = 32'h0;
    logic [31:0]      wb_dat_o;
    logic             wb_ack_o;
    logic             issue_valid;
    logic [15:0]      issue_low;
    logic [15:0]      issue_high;
    logic [31:0]      memory_word_operand;
    logic             exec_done;
    logic [FS_W-1:0]  float_status_register;
    logic             irq;
    logic [31:0]      rdata;
    int               n_mismatch = 0;
    int               samples_checked = 0;
    logic [31:0]      words [5] = '{32'h0, 32'h80000000, 32'h3f800000, 32'hc0000000, 32'h00000001};

    always #5 clk = ~clk;

    fmpmu_core #(.NREG(8)) dut (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .issue_valid(issue_valid), .issue_low(issue_low), .issue_high(issue_high),
        .memory_word_operand(memory_word_operand), .exec_done(exec_done),
        .float_status_register(float_status_register), .irq(irq));
    fmpmu_host host (.clk(clk), .issue_valid(issue_valid), .issue_low(issue_low), .issue_high(issue_high),
        .memory_word_operand(memory_word_operand));

    // ==========================================================
    // Bus and wait helpers
    task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 20);
        rdata = wb_dat_o;
        if (n >= 20) n_mismatch++;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic rd_expect(input logic [7:0] a, input logic [31:0] e);
        wb_xfer(1'b0, a, 32'h0);
        `CHK(rdata, e)
    endtask

    function automatic logic [7:0] rf_adr(input int i);
        return ADR_RF_BASE + 8'(i * 4);
    endfunction

    // Limitation: counts only a bounded wait, the checker pins the exact cycle
    task automatic wait_done;
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (exec_done !== 1'b1 && n < 10);
        `CHK(exec_done, 1'b1)
    endtask

    task automatic load4(input logic [31:0] r0, r1, r2, r3);
        wb_xfer(1'b1, rf_adr(0), r0);
        wb_xfer(1'b1, rf_adr(1), r1);
        wb_xfer(1'b1, rf_adr(2), r2);
        wb_xfer(1'b1, rf_adr(3), r3);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_regs;
        rd_expect(ADR_FSTAT, 32'h0);
        rd_expect(ADR_EVSTAT, 32'h0);
        for (int i = 0; i < 8; i++)
            rd_expect(rf_adr(i), 32'h0);
        wb_xfer(1'b1, 8'h40, 32'h5a5a5a5a);
        rd_expect(8'h40, 32'h0);
        wb_xfer(1'b1, ADR_EVEN, 32'h5);
        rd_expect(ADR_EVEN, 32'h5);
        rd_expect(ADR_EVCLR, 32'h0);
        wb_xfer(1'b1, ADR_EVEN, 32'h0);
    endtask

    task automatic t_mac_move;
        load4(32'h40000000, 32'h40400000, 32'h40000000, 32'h3f800000);
        wb_xfer(1'b1, ADR_FSTAT, 32'h40);
        host.mac_move(3'h1, 3'h0, 3'h5, 3'h6, 32'hc0a00000);
        `CHK(float_status_register[5:2], 4'h5)
        wait_done();
        rd_expect(rf_adr(3), 32'h40400000);
        rd_expect(rf_adr(5), 32'h40c00000);
        rd_expect(rf_adr(6), 32'hc0a00000);
        rd_expect(rf_adr(0), 32'h40000000);
        rd_expect(ADR_FSTAT, 32'h54);
    endtask

    task automatic t_flags;
        logic [3:0] exp_f;
        for (int i = 0; i < 5; i++)
        begin
            exp_f[0] = words[i][31] && (words[i][30:23] != 8'h00);
            exp_f[1] = (words[i][30:23] == 8'h00);
            exp_f[2] = words[i][31];
            exp_f[3] = (words[i] == 32'h0);
            host.mac_move(3'h0, 3'h0, 3'h4, 3'h5, words[i]);
            `CHK(float_status_register[5:2], exp_f)
            `CHK(float_status_register[FS_TF], 1'b1)
            wait_done();
        end
    endtask

    task automatic t_latch;
        load4(32'h7f7fffff, 32'h40000000, 32'h0, 32'h0);
        host.mac_move(3'h1, 3'h0, 3'h4, 3'h5, 32'h3f800000);
        wait_done();
        rd_expect(rf_adr(4), 32'h7f7fffff);
        `CHK(float_status_register[1:0], 2'h1)
        load4(32'h00800000, 32'h3f000000, 32'h0, 32'h0);
        host.mac_move(3'h1, 3'h0, 3'h4, 3'h5, 32'h3f800000);
        wait_done();
        rd_expect(rf_adr(4), 32'h0);
        `CHK(float_status_register[1:0], 2'h3)
        rd_expect(ADR_EVSTAT, 32'h7);
        `CHK(irq, 1'b0)
        wb_xfer(1'b1, ADR_EVEN, 32'h4);
        repeat (3) @(posedge clk);
        `CHK(irq, 1'b1)
        wb_xfer(1'b1, ADR_EVCLR, 32'h4);
        repeat (3) @(posedge clk);
        `CHK(irq, 1'b0)
        wb_xfer(1'b1, ADR_EVCLR, 32'hf);
        rd_expect(ADR_EVSTAT, 32'h0);
        wb_xfer(1'b1, ADR_EVEN, 32'h0);
    endtask

    task automatic t_par;
        load4(32'h0, 32'h40000000, 32'h40400000, 32'h3f800000);
        host.par(3'h0, 3'h1, 3'h2, 3'h3, 3'h3, 3'h2);
        wait_done();
        rd_expect(rf_adr(0), 32'h40c00000);
        rd_expect(rf_adr(3), 32'h40800000);
        host.par(3'h4, 3'h1, 3'h1, 3'h7, 3'h1, 3'h2);
        wait_done();
        rd_expect(rf_adr(4), 32'h40800000);
        rd_expect(rf_adr(7), 32'h40a00000);
        host.par(3'h4, 3'h1, 3'h1, 3'h4, 3'h1, 3'h2);
        // Both accepted pairs above left the done event set as well
        rd_expect(ADR_EVSTAT, 32'h9);
        rd_expect(rf_adr(4), 32'h40800000);
        wb_xfer(1'b1, ADR_EVCLR, 32'hf);
    endtask

    task automatic results;
        $display("Comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        #200000;
        n_mismatch++;
        results();
    end

    initial
    begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_mac_move();
        t_flags();
        t_latch();
        t_par();
        results();
    end
endmodule
